// [rtl/ftu_top.sv]
// four 8-bit timers: two plain on a shared prescaler, two multi-mode
// assumes the counter pins are asynchronous and settings come from plain ports
`timescale 1ns/1ps
module ftu_top (
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire ftu_pkg::ftu_load_s  i_pre_load,
  input  wire ftu_pkg::ftu_load_s  i_t1_load,
  input  wire ftu_pkg::ftu_load_s  i_t2_load,
  input  wire ftu_pkg::ftu_load_s  i_tx_load,
  input  wire ftu_pkg::ftu_load_s  i_ty_load,
  input  wire ftu_pkg::ftu_xy_ctl_s i_tx_ctl,
  input  wire ftu_pkg::ftu_xy_ctl_s i_ty_ctl,
  input  wire logic [7:0]          i_port_control_two,
  input  wire logic                i_ext_count_pin_a,
  input  wire logic                i_ext_count_pin_b,
  output logic                     o_ext_count_pin_a,
  output logic                     o_ext_count_pin_a_oe,
  output logic                     o_ext_count_pin_b,
  output logic                     o_ext_count_pin_b_oe,
  output logic [3:0]               o_irq_pulse,
  output logic [7:0]               o_t1_count,
  output logic [7:0]               o_t2_count,
  output logic [7:0]               o_tx_count,
  output logic [7:0]               o_ty_count
);
  import ftu_pkg::*;

  // ----------------------------------------------------------------
  // divide by 16 base tick and shared prescaler
  // ----------------------------------------------------------------
  logic [3:0] div16_reg;
  logic       tick16;
  logic       pre_uf;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div16_reg <= 4'h0;
    end else begin
      div16_reg <= (div16_reg == FTU_PRE_DIV) ? 4'h0 : div16_reg + 4'h1;
    end
  end
  assign tick16 = (div16_reg == FTU_PRE_DIV);

  ftu_down_counter #(.W(FTU_W)) u_pre (
    .i_clk        (i_clk),
    .i_resetn     (i_resetn),
    .i_load_we    (i_pre_load.we),
    .i_load_value (i_pre_load.value),
    .i_count_en   (tick16),
    .o_count      (),
    .o_underflow  (pre_uf)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // pins idle high, so a low reset value would fake a rising edge after reset
      pin_meta_reg <= 2'h3;
      pin_sync_reg <= 2'h3;
      pin_prev_reg <= 2'h3;
    end else begin
      pin_meta_reg <= {i_ext_count_pin_b, i_ext_count_pin_a};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // multi-mode count enables
  // ----------------------------------------------------------------
  // the base tick is an argument so a continuous assign re-evaluates on it
  function automatic logic xy_enable(input ftu_xy_ctl_s ctl, input logic src,
                                     input logic base,
                                     input logic lvl, input logic prev);
    logic en;
    en = 1'b0;
    case (ctl.mode)
      FTU_MODE_TIMER: en = src;
      FTU_MODE_PULSE: en = src;
      FTU_MODE_EVENT: en = ctl.edge_sel ? (prev && !lvl) : (!prev && lvl);
      FTU_MODE_WIDTH: en = base && (lvl == !ctl.edge_sel);
      default:        en = 1'b0;
    endcase
    xy_enable = en && !ctl.stop;
  endfunction

  // the alternate source is taken as the prescaler output
  logic ty_src;
  assign ty_src = i_port_control_two[FTU_SRC_SEL_BIT] ? pre_uf : tick16;

  logic [3:0] en;
  logic [3:0] uf;
  assign en[0] = pre_uf;
  assign en[1] = pre_uf;
  assign en[2] = xy_enable(i_tx_ctl, tick16, tick16, pin_sync_reg[0], pin_prev_reg[0]);
  assign en[3] = xy_enable(i_ty_ctl, ty_src, tick16, pin_sync_reg[1], pin_prev_reg[1]);

  ftu_load_s loads [4];
  logic [7:0] counts [4];
  assign loads[0] = i_t1_load;
  assign loads[1] = i_t2_load;
  assign loads[2] = i_tx_load;
  assign loads[3] = i_ty_load;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tmr
      ftu_down_counter #(.W(FTU_W)) u_tmr (
        .i_clk        (i_clk),
        .i_resetn     (i_resetn),
        .i_load_we    (loads[g].we),
        .i_load_value (loads[g].value),
        .i_count_en   (en[g]),
        .o_count      (counts[g]),
        .o_underflow  (uf[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt request pulses and pin outputs
  // ----------------------------------------------------------------
  logic [3:0] irq_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_reg <= 4'h0;
    end else begin
      irq_reg <= uf;
    end
  end
  assign o_irq_pulse = irq_reg;

  // pin level restarts from the inverted edge bit whenever the timer is not in pulse mode
  logic [1:0] pout_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pout_reg <= 2'h3;
    end else begin
      if (i_tx_ctl.mode != FTU_MODE_PULSE) begin
        pout_reg[0] <= !i_tx_ctl.edge_sel;
      end else if (uf[2]) begin
        pout_reg[0] <= !pout_reg[0];
      end
      if (i_ty_ctl.mode != FTU_MODE_PULSE) begin
        pout_reg[1] <= !i_ty_ctl.edge_sel;
      end else if (uf[3]) begin
        pout_reg[1] <= !pout_reg[1];
      end
    end
  end

  assign o_ext_count_pin_a    = pout_reg[0];
  assign o_ext_count_pin_b    = pout_reg[1];
  assign o_ext_count_pin_a_oe = (i_tx_ctl.mode == FTU_MODE_PULSE);
  assign o_ext_count_pin_b_oe = (i_ty_ctl.mode == FTU_MODE_PULSE);
  assign o_t1_count = counts[0];
  assign o_t2_count = counts[1];
  assign o_tx_count = counts[2];
  assign o_ty_count = counts[3];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_irq;
    @(posedge i_clk) disable iff (!i_resetn)
      (en[2] && counts[2] == 8'h00) |=> o_irq_pulse[2];
  endproperty
  a_irq: assert property (p_irq) else $error("underflow without request");

  property p_tick;
    @(posedge i_clk) disable iff (!i_resetn)
      tick16 |=> !tick16 [*8] ##1 !tick16 [*7] ##1 tick16;
  endproperty
  a_tick: assert property (p_tick) else $error("base tick too frequent");

  property p_plain;
    @(posedge i_clk) disable iff (!i_resetn)
      (pre_uf && counts[0] != 8'h00 && !i_t1_load.we) |=> (counts[0] == $past(counts[0]) - 8'h01);
  endproperty
  a_plain: assert property (p_plain) else $error("timer 1 missed prescaler pulse");

  property p_stop;
    @(posedge i_clk) disable iff (!i_resetn)
      i_tx_ctl.stop |-> !en[2];
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer counted");

  property p_toggle;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_tx_ctl.mode == FTU_MODE_PULSE && $past(i_tx_ctl.mode) == FTU_MODE_PULSE && uf[2])
        |=> (o_ext_count_pin_a != $past(o_ext_count_pin_a));
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin not inverted");

  property p_start;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_tx_ctl.mode != FTU_MODE_PULSE) |=> (o_ext_count_pin_a == !$past(i_tx_ctl.edge_sel));
  endproperty
  a_start: assert property (p_start) else $error("pulse start level wrong");

  property p_event;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_tx_ctl.mode == FTU_MODE_EVENT && !i_tx_ctl.stop && !i_tx_ctl.edge_sel
        && pin_sync_reg[0] && !pin_prev_reg[0]) |-> en[2];
  endproperty
  a_event: assert property (p_event) else $error("rising edge not counted");

  property p_width;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_tx_ctl.mode == FTU_MODE_WIDTH && en[2]) |-> (tick16 && pin_sync_reg[0] != i_tx_ctl.edge_sel);
  endproperty
  a_width: assert property (p_width) else $error("width count at wrong level");
endmodule

// [rtl/ftu_pkg.sv]
// package for the four timer unit: constants and carrier types
// assumes a single 50 MHz clock and plain control ports, no register bus
package ftu_pkg;
  localparam int          FTU_W          = 8;
  localparam logic [3:0]  FTU_PRE_DIV    = 4'hF;   // oscillator divided by 16
  localparam logic [7:0]  FTU_LATCH_RST  = 8'hFF;
  localparam logic [7:0]  FTU_COUNT_RST  = 8'hFF;
  localparam int          FTU_SRC_SEL_BIT = 5;     // count source select in port_control_two

  typedef enum logic [1:0] {
    FTU_MODE_TIMER,
    FTU_MODE_PULSE,
    FTU_MODE_EVENT,
    FTU_MODE_WIDTH
  } ftu_mode_e;

  // settings of one multi-mode timer
  typedef struct packed {
    ftu_mode_e  mode;
    logic       edge_sel;
    logic       stop;
  } ftu_xy_ctl_s;

  // reload latch write port
  typedef struct packed {
    logic       we;
    logic [7:0] value;
  } ftu_load_s;
endpackage

// [rtl/ftu_down_counter.sv]
// one 8-bit down counter with reload latch
// assumes a one-cycle count enable from the same clock domain
`timescale 1ns/1ps
module ftu_down_counter #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_load_we,
  input  wire logic [W-1:0] i_load_value,
  input  wire logic         i_count_en,
  output logic [W-1:0]      o_count,
  output logic              o_underflow
);
  import ftu_pkg::*;

  logic [W-1:0] latch_reg;
  logic [W-1:0] count_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_reg <= W'(FTU_LATCH_RST);
    end else if (i_load_we) begin
      latch_reg <= i_load_value;
    end
  end

  // a latch write while counting stays in the latch until the next underflow
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= W'(FTU_COUNT_RST);
    end else if (i_count_en) begin
      if (count_reg == '0) begin
        count_reg <= latch_reg;
      end else begin
        count_reg <= count_reg - W'(1);
      end
    end
  end

  assign o_count     = count_reg;
  assign o_underflow = i_count_en && (count_reg == '0);

  property p_reload;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_count_en && count_reg == '0 && !i_load_we) |=> (count_reg == $past(latch_reg));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on underflow");

  property p_hold;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_count_en |=> $stable(count_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without enable");
endmodule

// [bench/ftu_pin_model.sv]
// far-side model of the two external counter pins
// assumes the bench calls its tasks at the falling clock edge
`timescale 1ns/1ps
module ftu_pin_model (
  input  wire logic i_clk,
  input  wire logic i_dev_a,
  input  wire logic i_oe_a,
  input  wire logic i_dev_b,
  input  wire logic i_oe_b,
  output logic      o_pin_a,
  output logic      o_pin_b
);
  logic drv_a = 1'b1;
  logic drv_b = 1'b1;
  // the device wins the wire while its enable is high
  assign o_pin_a = i_oe_a ? i_dev_a : drv_a;
  assign o_pin_b = i_oe_b ? i_dev_b : drv_b;

  task automatic set(input bit b, input logic lvl);
    if (b) drv_b = lvl;
    else drv_a = lvl;
  endtask

  // pulses at least three clocks wide, so the synchroniser never drops one
  task automatic pulses(input bit b, input int n, input logic idle);
    repeat (n) begin
      set(b, ~idle);
      repeat (4) @(negedge i_clk);
      set(b, idle);
      repeat (4) @(negedge i_clk);
    end
  endtask
endmodule

// [bench/four_timer_unit_test.sv]
// self-checking bench for the four timer unit
// assumes the pin model drives the counter pins and settings are plain ports
`timescale 1ns/1ps
module four_timer_unit_test;
  import ftu_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  ftu_load_s   ld [5];
  ftu_xy_ctl_s tx_ctl;
  ftu_xy_ctl_s ty_ctl;
  logic [7:0]  pctl = 8'h00;
  logic        pin_a, pin_b, dev_a, oe_a, dev_b, oe_b;
  logic [3:0]  irq;
  logic [7:0]  cnt [4];
  logic [7:0]  d;
  logic [7:0]  q;
  int          failures = 0;
  int          total_checks = 0;
  int          n, m, k, e;

  always #10 i_clk = ~i_clk;

  ftu_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_pre_load(ld[0]), .i_t1_load(ld[1]),
    .i_t2_load(ld[2]), .i_tx_load(ld[3]), .i_ty_load(ld[4]), .i_tx_ctl(tx_ctl),
    .i_ty_ctl(ty_ctl), .i_port_control_two(pctl), .i_ext_count_pin_a(pin_a),
    .i_ext_count_pin_b(pin_b), .o_ext_count_pin_a(dev_a), .o_ext_count_pin_a_oe(oe_a),
    .o_ext_count_pin_b(dev_b), .o_ext_count_pin_b_oe(oe_b), .o_irq_pulse(irq),
    .o_t1_count(cnt[0]), .o_t2_count(cnt[1]), .o_tx_count(cnt[2]), .o_ty_count(cnt[3]));

  ftu_pin_model pin (.i_clk(i_clk), .i_dev_a(dev_a), .i_oe_a(oe_a), .i_dev_b(dev_b),
    .i_oe_b(oe_b), .o_pin_a(pin_a), .o_pin_b(pin_b));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi,
                     input string msg);
    total_checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s got %0h want %0h..%0h", $time, msg, got, lo, hi);
    end
  endtask

  task automatic load(input int i, input logic [7:0] v);
    @(negedge i_clk);
    ld[i] = '{1'b1, v};
    @(negedge i_clk);
    ld[i].we = 1'b0;
  endtask

  // cycles up to the next interrupt pulse, bounded
  task automatic wait_irq(input int i, output int cyc);
    cyc = 0;
    do begin
      @(negedge i_clk);
      cyc++;
    end while (irq[i] !== 1'b1 && cyc < 20000);
    if (cyc >= 20000) begin
      failures++;
      $display("[FAIL] %0t no interrupt %0d", $time, i);
    end
  endtask

  // counter value after n count pulses from c, reloading lat on underflow
  function automatic logic [7:0] after_n(input logic [7:0] c, input int n,
                                         input logic [7:0] lat);
    logic [7:0] v;
    v = c;
    repeat (n) begin
      v = (v == 8'h00) ? lat : v - 8'h01;
    end
    return v;
  endfunction

  task automatic span(input int cyc, output logic [7:0] delta);
    logic [7:0] c0;
    c0 = cnt[3];
    repeat (cyc) @(negedge i_clk);
    delta = c0 - cnt[3];
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge i_clk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    foreach (ld[i]) ld[i] = '0;
    tx_ctl = '{FTU_MODE_TIMER, 1'b0, 1'b1};
    ty_ctl = '{FTU_MODE_TIMER, 1'b0, 1'b1};
    void'($urandom(32'hdecd4134));
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    chk(cnt[0], 8'hFF, 8'hFF, "t1 reset");
    chk({4'h0, irq}, 8'h00, 8'h00, "irq reset");
    $display("reset test done");
    n = $urandom % 2;
    m = $urandom % 4;
    load(0, 8'(n));
    load(1, 8'(m));
    load(2, 8'h00);
    wait_irq(0, k);
    wait_irq(0, k);
    chk(8'(k), 8'(16*(n+1)*(m+1)), 8'(16*(n+1)*(m+1)), "t1 period");
    chk(cnt[0], 8'(m), 8'(m), "t1 reload");
    wait_irq(1, k);
    wait_irq(1, k);
    chk(8'(k), 8'(16*(n+1)), 8'(16*(n+1)), "t2 period");
    chk(cnt[1], 8'h00, 8'h00, "t2 reload");
    $display("plain timer test done");
    m = $urandom % 8;
    load(3, 8'(m));
    tx_ctl.stop = 1'b0;
    wait_irq(2, k);
    wait_irq(2, k);
    chk(8'(k), 8'(16*(m+1)), 8'(16*(m+1)), "x period");
    e = $urandom % 2;
    tx_ctl.edge_sel = e[0];
    repeat (2) @(negedge i_clk);
    tx_ctl.mode = FTU_MODE_PULSE;
    @(negedge i_clk);
    chk({7'h0, oe_a}, 8'h01, 8'h01, "pulse enable");
    chk({7'h0, pin_a}, 8'(!e), 8'(!e), "pulse start");
    for (int j = 0; j < 2; j++) begin
      wait_irq(2, k);
      repeat (2) @(negedge i_clk);
      chk({7'h0, pin_a}, 8'(j == 0 ? e : !e), 8'(j == 0 ? e : !e), "pulse toggle");
    end
    tx_ctl.stop = 1'b1;
    @(negedge i_clk);
    d = cnt[2];
    repeat (100) @(negedge i_clk);
    chk(cnt[2], d, d, "x stopped");
    $display("timer x test done");
    for (int b = 0; b < 2; b++) begin
      for (e = 0; e < 2; e++) begin
        pin.set(b[0], e[0]);
        if (b == 0) begin
          tx_ctl = '{FTU_MODE_EVENT, e[0], 1'b0};
        end else begin
          ty_ctl = '{FTU_MODE_EVENT, e[0], 1'b0};
        end
        repeat (5) @(negedge i_clk);
        d = cnt[2+b];
        k = 1 + $urandom % 10;
        pin.pulses(b[0], k, e[0]);
        repeat (5) @(negedge i_clk);
        d = after_n(d, k, (b == 0) ? 8'(m) : 8'hFF);
        chk(cnt[2+b], d, d, "event count");
      end
    end
    tx_ctl = '{FTU_MODE_WIDTH, 1'b1, 1'b0};
    ty_ctl = '{FTU_MODE_WIDTH, 1'b0, 1'b0};
    pin.set(1'b0, 1'b0);
    pin.set(1'b1, 1'b0);
    repeat (5) @(negedge i_clk);
    q = cnt[2];
    span(160, d);
    chk(d, 8'h00, 8'h00, "width low");
    chk(cnt[2], after_n(q, 10, 8'(m)), after_n(q, 10, 8'(m)), "x width low");
    pin.set(1'b0, 1'b1);
    pin.set(1'b1, 1'b1);
    repeat (5) @(negedge i_clk);
    q = cnt[2];
    span(160, d);
    chk(d, 8'h09, 8'h0B, "width high");
    chk(cnt[2], q, q, "x width high");
    ty_ctl.stop = 1'b1;
    @(negedge i_clk);
    span(100, d);
    chk(d, 8'h00, 8'h00, "y stopped");
    $display("timer y test done");
    load(0, 8'h03);
    repeat (200) @(negedge i_clk);
    ty_ctl = '{FTU_MODE_TIMER, 1'b0, 1'b0};
    pctl = 8'h20;
    span(640, d);
    chk(d, 8'h09, 8'h0B, "y prescaled");
    pctl = 8'h00;
    span(640, d);
    chk(d, 8'h27, 8'h29, "y direct");
    $display("source test done");
    load(4, 8'h01);
    ty_ctl.edge_sel = 1'b1;
    @(negedge i_clk);
    ty_ctl.mode = FTU_MODE_PULSE;
    @(negedge i_clk);
    chk({7'h0, oe_b}, 8'h01, 8'h01, "y pulse enable");
    chk({7'h0, pin_b}, 8'h00, 8'h00, "y pulse start");
    wait_irq(3, k);
    chk({7'h0, pin_b}, 8'h01, 8'h01, "y pulse toggle");
    wait_irq(3, k);
    chk(8'(k), 8'h20, 8'h20, "y pulse period");
    chk({7'h0, pin_b}, 8'h00, 8'h00, "y pulse back");
    $display("y pulse test done");
    test_done();
  end
endmodule
